// ==== logic/hspc_pkg.sv ====
// Constants, field layout and carrier types for the port control upper half
package hspc_pkg;

  // ==========================================================================
  // Field positions inside the port status and control word
  localparam int HSPC_WORD_W = 32;
  localparam int HSPC_RSVD_MSB = 31;
  localparam int HSPC_RSVD_LSB = 23;
  localparam int HSPC_WAKE_OC_BIT = 22;
  localparam int HSPC_WAKE_DISC_BIT = 21;
  localparam int HSPC_WAKE_CONN_BIT = 20;
  localparam int HSPC_TEST_MSB = 19;
  localparam int HSPC_TEST_LSB = 16;
  localparam int HSPC_IND_MSB = 15;
  localparam int HSPC_IND_LSB = 14;
  localparam int HSPC_OWN_BIT = 13;

  // ==========================================================================
  // Reset values
  localparam logic HSPC_WAKE_RESET = 1'h0;
  localparam logic [3:0] HSPC_TEST_RESET = 4'h0;
  localparam logic [1:0] HSPC_IND_RESET = 2'h0;
  localparam logic HSPC_OWN_RESET = 1'h1;
  localparam logic [1:0] HSPC_RST_SYNC_RESET = 2'h0;

  // ==========================================================================
  // Test selector encodings; codes above force_enable are reserved
  typedef enum logic [3:0] {
    HSPC_TEST_NONE = 4'b0000,
    HSPC_TEST_J = 4'b0001,
    HSPC_TEST_K = 4'b0010,
    HSPC_TEST_SE0_NAK = 4'b0011,
    HSPC_TEST_PACKET = 4'b0100,
    HSPC_TEST_FORCE_EN = 4'b0101
  } hspc_test_code_type;

  // Indicator selector encodings; 2'b11 is undefined and shows nothing
  typedef enum logic [1:0] {
    HSPC_IND_OFF = 2'b00,
    HSPC_IND_AMBER = 2'b01,
    HSPC_IND_GREEN = 2'b10
  } hspc_ind_code_type;

  // Software-visible control fields
  typedef struct packed {
    logic wake_overcurrent_enable;
    logic wake_disconnect_enable;
    logic wake_connect_enable;
    logic [3:0] port_test_select;
    logic [1:0] port_indicator_select;
    logic companion_ownership;
  } hspc_ctrl_type;

  // Decoded test drive towards the port transceiver
  typedef struct packed {
    logic active;
    logic drive_j;
    logic drive_k;
    logic se0_nak;
    logic packet;
    logic force_enable;
  } hspc_test_type;

  // Indicator lamps
  typedef struct packed {
    logic amber;
    logic green;
  } hspc_lamp_type;

endpackage

// ==== logic/hspc_port_ctrl.sv ====
// Port status and control upper half: wake enables, test mode, indicators
`timescale 1ns/1ns
module hspc_port_ctrl
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic reg_wr_en_in,
  input wire logic [31:0] reg_wr_data_in,
  output logic [31:0] reg_rd_data_out,
  input wire logic indicator_cap_in,
  input wire logic configured_flag_in,
  input wire logic connect_status_in,
  input wire logic overcurrent_in,
  output logic wake_event_out,
  output hspc_pkg::hspc_test_type test_drive_out,
  output hspc_pkg::hspc_lamp_type lamp_out,
  output logic companion_ownership_out
);
  import hspc_pkg::*;

  // ==========================================================================
  // Reset release
  logic [1:0] rst_sync_r;
  logic rst_n;

  // Assertion is immediate, release waits two edges to avoid metastable exit
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rst_sync_r <= HSPC_RST_SYNC_RESET;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // ==========================================================================
  // Decode helpers
  function automatic hspc_test_type decode_test(input logic [3:0] code);
    hspc_test_type t;
    t = '0;
    t.active = (code != HSPC_TEST_NONE);
    t.drive_j = (code == HSPC_TEST_J);
    t.drive_k = (code == HSPC_TEST_K);
    t.se0_nak = (code == HSPC_TEST_SE0_NAK);
    t.packet = (code == HSPC_TEST_PACKET);
    t.force_enable = (code == HSPC_TEST_FORCE_EN);
    return t;
  endfunction

  function automatic hspc_lamp_type decode_lamp(input logic cap, input logic [1:0] code);
    hspc_lamp_type l;
    l.amber = cap && (code == HSPC_IND_AMBER);
    l.green = cap && (code == HSPC_IND_GREEN);
    return l;
  endfunction

  // ==========================================================================
  // Control fields
  hspc_ctrl_type ctrl_r;
  hspc_ctrl_type ctrl_nxt;
  logic cf_prev_r;
  logic cf_prev_nxt;

  // Software write, then hardware ownership override which always wins
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    cf_prev_nxt = configured_flag_in;
    if (reg_wr_en_in)
    begin
      // Bits 31..23 have no storage, so writes there vanish
      ctrl_nxt.wake_overcurrent_enable = reg_wr_data_in[HSPC_WAKE_OC_BIT];
      ctrl_nxt.wake_disconnect_enable = reg_wr_data_in[HSPC_WAKE_DISC_BIT];
      ctrl_nxt.wake_connect_enable = reg_wr_data_in[HSPC_WAKE_CONN_BIT];
      // Reserved codes are stored as written; for them the decoder raises only active
      ctrl_nxt.port_test_select = reg_wr_data_in[HSPC_TEST_MSB:HSPC_TEST_LSB];
      if (indicator_cap_in)
        ctrl_nxt.port_indicator_select = reg_wr_data_in[HSPC_IND_MSB:HSPC_IND_LSB];
      ctrl_nxt.companion_ownership = reg_wr_data_in[HSPC_OWN_BIT];
    end
    if (!configured_flag_in)
      ctrl_nxt.companion_ownership = 1'b1;
    else if (!cf_prev_r)
      ctrl_nxt.companion_ownership = 1'b0;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r.wake_overcurrent_enable <= HSPC_WAKE_RESET;
      ctrl_r.wake_disconnect_enable <= HSPC_WAKE_RESET;
      ctrl_r.wake_connect_enable <= HSPC_WAKE_RESET;
      ctrl_r.port_test_select <= HSPC_TEST_RESET;
      ctrl_r.port_indicator_select <= HSPC_IND_RESET;
      ctrl_r.companion_ownership <= HSPC_OWN_RESET;
      cf_prev_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      cf_prev_r <= cf_prev_nxt;
    end
  end

  // ==========================================================================
  // Wake detection and decoded outputs
  logic oc_prev_r;
  logic conn_prev_r;
  logic wake_r;
  hspc_test_type test_r;
  hspc_lamp_type lamp_r;
  logic oc_prev_nxt;
  logic conn_prev_nxt;
  logic wake_nxt;
  hspc_test_type test_nxt;
  hspc_lamp_type lamp_nxt;

  // Edges only: a level held high must not keep waking the system
  always_comb
  begin
    oc_prev_nxt = overcurrent_in;
    conn_prev_nxt = connect_status_in;
    wake_nxt = (ctrl_r.wake_overcurrent_enable && overcurrent_in && !oc_prev_r)
      || (ctrl_r.wake_disconnect_enable && !connect_status_in && conn_prev_r)
      || (ctrl_r.wake_connect_enable && connect_status_in && !conn_prev_r);
    test_nxt = decode_test(ctrl_r.port_test_select);
    lamp_nxt = decode_lamp(indicator_cap_in, ctrl_r.port_indicator_select);
  end

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oc_prev_r <= 1'b0;
      conn_prev_r <= 1'b0;
      wake_r <= 1'b0;
      test_r <= '0;
      lamp_r <= '0;
    end
    else
    begin
      oc_prev_r <= oc_prev_nxt;
      conn_prev_r <= conn_prev_nxt;
      wake_r <= wake_nxt;
      test_r <= test_nxt;
      lamp_r <= lamp_nxt;
    end
  end

  // ==========================================================================
  // Outputs; bits below 13 belong to other logic and read zero here
  assign wake_event_out = wake_r;
  assign test_drive_out = test_r;
  assign lamp_out = lamp_r;
  assign companion_ownership_out = ctrl_r.companion_ownership;
  assign reg_rd_data_out = {9'h000,
    ctrl_r.wake_overcurrent_enable, ctrl_r.wake_disconnect_enable,
    ctrl_r.wake_connect_enable, ctrl_r.port_test_select,
    ctrl_r.port_indicator_select, ctrl_r.companion_ownership, 13'h0000};

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n);

  a_oc_wake_pulse: assert property (
    ctrl_r.wake_overcurrent_enable && $rose(overcurrent_in) |=> wake_event_out)
    else $error("overcurrent edge gave no wake");
  a_disc_wake_pulse: assert property (
    ctrl_r.wake_disconnect_enable && $fell(connect_status_in) |=> wake_event_out)
    else $error("disconnect edge gave no wake");
  a_conn_wake_pulse: assert property (
    ctrl_r.wake_connect_enable && $rose(connect_status_in) |=> wake_event_out)
    else $error("connect edge gave no wake");
  a_no_spurious_wake: assert property (
    !(ctrl_r.wake_overcurrent_enable && $rose(overcurrent_in))
    && !(ctrl_r.wake_disconnect_enable && $fell(connect_status_in))
    && !(ctrl_r.wake_connect_enable && $rose(connect_status_in)) |=> !wake_event_out)
    else $error("wake without enabled event");
  a_test_mode_drive: assert property (
    reg_wr_en_in
    && reg_wr_data_in[HSPC_TEST_MSB:HSPC_TEST_LSB] == HSPC_TEST_J
    |=> ##1 test_drive_out.drive_j
    && test_drive_out.active && !test_drive_out.drive_k)
    else $error("test J not driven two cycles after write");
  a_test_reserved_quiet: assert property (
    ctrl_r.port_test_select > 4'h5 |=> test_drive_out.active
    && !(test_drive_out.drive_j || test_drive_out.drive_k || test_drive_out.se0_nak
    || test_drive_out.packet || test_drive_out.force_enable))
    else $error("reserved test code drives the port");
  a_ind_write_ignored: assert property (
    reg_wr_en_in && !indicator_cap_in |=> $stable(ctrl_r.port_indicator_select))
    else $error("indicator changed without capability");
  a_ind_lamp_map: assert property (
    indicator_cap_in && ctrl_r.port_indicator_select == 2'h1
    |=> lamp_out.amber && !lamp_out.green)
    else $error("amber code not shown");
  a_own_forced_high: assert property (
    !configured_flag_in |=> companion_ownership_out)
    else $error("ownership not forced while unconfigured");
  a_own_clear_rise: assert property (
    configured_flag_in && !cf_prev_r |=> !companion_ownership_out)
    else $error("ownership not cleared on configure");
  a_rsvd_read_zero: assert property (
    reg_wr_en_in |=> reg_rd_data_out[HSPC_RSVD_MSB:HSPC_RSVD_LSB] == '0
    && reg_rd_data_out[HSPC_OWN_BIT-1:0] == '0)
    else $error("reserved bits not zero");

  c_wake_seen: cover property (wake_event_out);
  c_test_packet: cover property (test_drive_out.packet);
  c_green_lamp: cover property (lamp_out.green);
  c_own_released: cover property ($fell(companion_ownership_out));

endmodule

// ==== testbench/hspc_dev_model.sv ====
// Behavioural model of a device on the downstream port
`timescale 1ns/1ns
module hspc_dev_model
(
  input wire logic clk_sys_in,
  input wire logic attach_in,
  input wire logic fault_in,
  output logic connect_status_out,
  output logic overcurrent_out
);
  // =====================================================
  // Attach and fault settle one clock late, as a debounced pin would
  always_ff @(posedge clk_sys_in)
  begin
    connect_status_out <= attach_in;
    overcurrent_out <= fault_in;
  end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the port control upper half
`timescale 1ns/1ns
module tb;
  import hspc_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic reg_wr_en_in = 1'b0;
  logic [31:0] reg_wr_data_in = 32'h0;
  logic indicator_cap_in = 1'b0;
  logic configured_flag_in = 1'b0;
  logic attach = 1'b0;
  logic fault = 1'b0;
  logic conn, oc, wake_event_out, companion_ownership_out;
  logic [31:0] reg_rd_data_out;
  hspc_test_type test_drive_out;
  hspc_lamp_type lamp_out;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  // =====================================================
  // Design and far-side model
  hspc_port_ctrl hspc_port_ctrl_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .reg_wr_en_in(reg_wr_en_in), .reg_wr_data_in(reg_wr_data_in),
    .reg_rd_data_out(reg_rd_data_out), .indicator_cap_in(indicator_cap_in),
    .configured_flag_in(configured_flag_in), .connect_status_in(conn),
    .overcurrent_in(oc), .wake_event_out(wake_event_out), .test_drive_out(test_drive_out),
    .lamp_out(lamp_out), .companion_ownership_out(companion_ownership_out));
  hspc_dev_model hspc_dev_model_i (.clk_sys_in(clk_sys_in), .attach_in(attach),
    .fault_in(fault), .connect_status_out(conn), .overcurrent_out(oc));
  // =====================================================
  // Clock and hang guard; the whole run needs well under 400 cycles
  initial
  begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  // =====================================================
  // Shared helpers
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Strobe drops on the edge that samples it, so writes never overlap
  task automatic wr(input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_wr_en_in <= 1'b1;
    reg_wr_data_in <= d;
    @(posedge clk_sys_in);
    reg_wr_en_in <= 1'b0;
    #1;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  // Counting pulses over a window avoids guessing the exact pulse edge
  task automatic pulses(input int exp);
    int cnt;
    cnt = 0;
    repeat (6)
    begin
      @(posedge clk_sys_in);
      #1;
      // An unknown wake output counts as a pulse so it cannot slip through
      if (wake_event_out !== 1'b0)
        cnt++;
    end
    chk(cnt, exp);
  endtask
  // =====================================================
  // Scenarios
  task automatic t_reset();
    chk(reg_rd_data_out, 32'h00002000);
    chk({test_drive_out, lamp_out}, 8'h00);
  endtask
  // Reserved upper bits are set in every loop write; only defined codes are used
  task automatic t_test();
    for (int c = 1; c <= 5; c++)
    begin
      wr(32'hFF800000 | (c << 16));
      chk(reg_rd_data_out, 32'h00002000 | (c << 16));
      step(1);
      chk(test_drive_out, {1'b1, 5'h10 >> (c - 1)});
    end
    wr(32'h0);
    step(1);
    chk(test_drive_out, 6'h00);
  endtask
  task automatic t_ind();
    wr(32'h00004000);
    chk(reg_rd_data_out[15:14], 2'h0);
    @(posedge clk_sys_in);
    indicator_cap_in <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      wr(i << 14);
      chk(reg_rd_data_out[15:14], i);
      step(1);
      chk(lamp_out, (i == 1) ? 2'h2 : (i == 2) ? 2'h1 : 2'h0);
    end
    // Capability withdrawn: stored green code holds, lamps go dark
    @(posedge clk_sys_in);
    indicator_cap_in <= 1'b0;
    wr(32'h0);
    chk(reg_rd_data_out[15:14], 2'h2);
    chk(lamp_out, 2'h0);
  endtask
  task automatic t_wake();
    wr(32'h00700000);
    attach <= 1'b1;
    pulses(1);
    attach <= 1'b0;
    pulses(1);
    fault <= 1'b1;
    pulses(1);
    fault <= 1'b0;
    pulses(0);
    wr(32'h0);
    fault <= 1'b1;
    pulses(0);
    attach <= 1'b1;
    pulses(0);
  endtask
  task automatic t_own();
    @(posedge clk_sys_in);
    configured_flag_in <= 1'b1;
    step(3);
    chk(companion_ownership_out, 1'b0);
    wr(32'h00002000);
    chk(reg_rd_data_out[13], 1'b1);
    @(posedge clk_sys_in);
    configured_flag_in <= 1'b0;
    step(3);
    wr(32'h0);
    chk(companion_ownership_out, 1'b1);
  endtask
  // =====================================================
  // Main sequence: reset for three cycles, then the scenarios
  initial
  begin
    repeat (3) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    step(3);
    t_reset();
    t_test();
    t_ind();
    t_wake();
    t_own();
    give_verdict();
  end
endmodule
